// ### include/spimsp_pkg.sv
// constants and shared types for the spi master/slave port
// assumes a 100 MHz mclk and a byte-wide command side in the same domain
//
// What this block does
// - the port has miso, mosi, sclk and cs lines and runs four-line full or three-line half duplex.
// - as full-duplex master it reads miso and drives mosi, sclk and cs, owning all timing.
// - as full-duplex slave it drives miso while cs is low and reads mosi, sclk and cs from the outside master.
// - chip select is active low in both roles.
// - in half duplex miso is idle and mosi is one shared data line, driven only while sending.
// - as master, queued send bytes are shifted out and a receive command returns shifted-in bytes.
// - in manual select mode cs moves on a set command, high for 1 and low for 0, or on a select code riding with a byte.
// - a select code riding with a byte drives cs low before it or high after it.
// - as slave, send data must be loaded before the select edge, or before the previous byte's last bit when cs stays low.
// - as slave, loaded bytes are held in a buffer and leave on master clock edges, the first bit on the select edge when clock phase is 0.
// - as slave, a receive command waits until a byte has arrived and then returns it.
// - as master a three-bit setting targets 24 MHz halved per step down to 187.5 kHz, half periods rounded up to whole mclk cycles.
// - clock polarity sets the idle level and clock phase picks first or second edge sampling.
// - each byte is shifted msb first or lsb first as selected.
// - in automatic select mode cs frames every byte as master; as slave cs comes from the outside master and may stay low across bytes.
package spimsp_pkg;
   localparam int MCLK_HZ = 100_000_000;
   localparam int SCLK_FAST_HZ = 24_000_000;
   localparam int DIV_W = 9;
   localparam int SEL_W = 3;
   localparam int SEL_N = 8;
   localparam int PIN_MISO = 0;
   localparam int PIN_MOSI = 1;
   localparam int PIN_SCLK = 2;
   localparam int PIN_CS = 3;
   localparam logic [1:0] CS_CODE_NONE = 2'h0;
   localparam logic [1:0] CS_CODE_LOW = 2'h1;
   localparam logic [1:0] CS_CODE_HIGH = 2'h2;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam logic [4:0] LAST_EDGE = 5'h0F;
   localparam logic [3:0] LAST_BIT = 4'h7;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_XFER, ST_DONE} spimsp_state_t;
endpackage

// ### include/spimsp_tick_if.sv
// half-period tick link between the port core and its clock divider
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none
interface spimsp_tick_if;
   logic [2:0] sel;
   logic run;
   logic tick;
   modport gen (input sel, input run, output tick);
   modport user (output sel, output run, input tick);
endinterface
`default_nettype wire

// ### verilog/spimsp_clkgen.sv
// serial clock divider: one tick per half period of the chosen rate
// assumes run is held for the whole of a master byte
`timescale 1ns/1ps
`default_nettype none
module spimsp_clkgen
   import spimsp_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   spimsp_tick_if.gen tk
);
   import spimsp_pkg::*;
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic tick;
   } spimsp_div_t;
   spimsp_div_t r;
   spimsp_div_t next_r;
   logic [DIV_W-1:0] tbl [SEL_N];
   // least half period rounds up: 24 MHz cannot be reached from 100 MHz
   for (genvar g = 0; g < SEL_N; g++) begin : g_tbl
      assign tbl[g] = DIV_W'((MCLK_HZ + (SCLK_FAST_HZ >> g) * 2 - 1)
                             / ((SCLK_FAST_HZ >> g) * 2));
   end
   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      if (!tk.run) begin
         next_r.cnt = '0;
      end else if (r.cnt >= tbl[tk.sel] - DIV_W'(1)) begin
         next_r.cnt = '0;
         next_r.tick = 1'b1;
      end else begin
         next_r.cnt = r.cnt + DIV_W'(1);
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign tk.tick = r.tick;
endmodule
`default_nettype wire

// ### verilog/spimsp_core.sv
// spi port core: master or slave, full or half duplex, one-byte buffers
// assumes command inputs are synchronous to mclk; pins pass two flip-flops
`timescale 1ns/1ps
`default_nettype none
module spimsp_core
   import spimsp_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic master_mode,
   input wire logic half_duplex,
   input wire logic [spimsp_pkg::SEL_W-1:0] clk_sel,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb_first,
   input wire logic manual_select_mode,
   input wire logic chip_select_set_command,
   input wire logic cs_set_value,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic [1:0] tx_cs_code,
   output logic tx_ready,
   input wire logic clear_tx,
   input wire logic spi_receive_command,
   input wire logic [1:0] rx_cs_code,
   input wire logic clear_rx,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic cs_level,
   output logic busy,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_n,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_n,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe_n,
   input wire logic cs_in,
   output logic cs_out,
   output logic cs_oe_n
);
   import spimsp_pkg::*;

   typedef struct packed {
      spimsp_state_t st;
      logic [3:0] s1;
      logic [3:0] s2;
      logic sclk_p;
      logic cs_p;
      logic [7:0] tx_sr;
      logic [7:0] rx_sr;
      logic [4:0] edges;
      logic [3:0] bits;
      logic [7:0] tx_hold;
      logic tx_full;
      logic [1:0] tx_code;
      logic [1:0] cur_code;
      logic drive;
      logic [7:0] rx_hold;
      logic rx_full;
      logic rx_wait;
      logic [1:0] rx_code;
      logic cs_reg;
      logic sclk_o;
      logic out_bit;
      logic miso_out;
      logic miso_oe_n;
      logic mosi_out;
      logic mosi_oe_n;
      logic sclk_out;
      logic sclk_oe_n;
      logic cs_out;
      logic cs_oe_n;
      logic tx_ready;
      logic rx_valid;
      logic [7:0] rx_data;
      logic cs_level;
      logic busy;
   } spimsp_core_t;

   localparam spimsp_core_t CORE_RST = '{
      st: ST_IDLE,
      s1: 4'hF,
      s2: 4'hF,
      sclk_p: 1'b1,
      cs_p: 1'b1,
      tx_sr: 8'h00,
      rx_sr: 8'h00,
      edges: 5'h00,
      bits: 4'h0,
      tx_hold: 8'h00,
      tx_full: 1'b0,
      tx_code: CS_CODE_NONE,
      cur_code: CS_CODE_NONE,
      drive: 1'b0,
      rx_hold: 8'h00,
      rx_full: 1'b0,
      rx_wait: 1'b0,
      rx_code: CS_CODE_NONE,
      cs_reg: 1'b1,
      sclk_o: 1'b0,
      out_bit: 1'b0,
      miso_out: 1'b0,
      miso_oe_n: 1'b1,
      mosi_out: 1'b0,
      mosi_oe_n: 1'b1,
      sclk_out: 1'b0,
      sclk_oe_n: 1'b1,
      cs_out: 1'b1,
      cs_oe_n: 1'b1,
      tx_ready: 1'b1,
      rx_valid: 1'b0,
      rx_data: 8'h00,
      cs_level: 1'b1,
      busy: 1'b0
   };

   spimsp_core_t r;
   spimsp_core_t next_r;
   spimsp_tick_if tk();

   // bit presented next, in the selected order
   function automatic logic out_of(input logic [7:0] sr, input logic lsb);
      out_of = lsb ? sr[0] : sr[7];
   endfunction

   function automatic logic [7:0] shift_of(input logic [7:0] sr, input logic lsb);
      shift_of = lsb ? {1'b0, sr[7:1]} : {sr[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] ins_of(input logic [7:0] sr, input logic lsb,
                                         input logic din);
      ins_of = lsb ? {din, sr[7:1]} : {sr[6:0], din};
   endfunction

   assign tk.sel = clk_sel;
   assign tk.run = enable && master_mode && (r.st != ST_IDLE);

   spimsp_clkgen i_spimsp_clkgen (
      .mclk(mclk),
      .nrst(nrst),
      .tk(tk.gen)
   );

   always_comb begin
      logic rx_done;
      logic lead;
      logic sel_n;
      logic din;
      rx_done = 1'b0;
      lead = 1'b0;
      sel_n = 1'b1;
      din = 1'b0;
      next_r = r;
      // pins pass two flops; only s2 is read by logic
      next_r.s1 = {cs_in, sclk_in, mosi_in, miso_in};
      next_r.s2 = r.s1;
      next_r.sclk_p = r.s2[PIN_SCLK];
      next_r.cs_p = r.s2[PIN_CS];
      next_r.rx_valid = 1'b0;

      // one-byte send buffer, refused while full
      if (clear_tx) begin
         next_r.tx_full = 1'b0;
      end else if (tx_valid && !r.tx_full) begin
         next_r.tx_hold = tx_data;
         next_r.tx_code = tx_cs_code;
         next_r.tx_full = 1'b1;
      end
      if (spi_receive_command) begin
         next_r.rx_wait = 1'b1;
         next_r.rx_code = rx_cs_code;
      end
      if (chip_select_set_command && manual_select_mode && master_mode) begin
         next_r.cs_reg = cs_set_value;
      end

      if (!enable) begin
         next_r.st = ST_IDLE;
         next_r.sclk_o = cpol;
         next_r.bits = '0;
      end else if (master_mode) begin
         din = half_duplex ? r.s2[PIN_MOSI] : r.s2[PIN_MISO];
         unique case (r.st)
            ST_IDLE: begin
               next_r.sclk_o = cpol;
               next_r.edges = '0;
               // a receive with nothing queued clocks a fill byte out while a byte shifts in
               if (r.tx_full || (r.rx_wait && !r.rx_full)) begin
                  next_r.drive = r.tx_full;
                  next_r.tx_sr = r.tx_full ? r.tx_hold : FILL_BYTE;
                  next_r.cur_code = r.tx_full ? r.tx_code : r.rx_code;
                  if (r.tx_full && !(tx_valid && clear_tx)) begin
                     next_r.tx_full = 1'b0;
                  end
                  next_r.st = ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (tk.tick) begin
                  if (!manual_select_mode) begin
                     next_r.cs_reg = 1'b0;
                  end else if (r.cur_code == CS_CODE_LOW) begin
                     next_r.cs_reg = 1'b0;
                  end
                  if (!cpha) begin
                     next_r.out_bit = out_of(r.tx_sr, lsb_first);
                     next_r.tx_sr = shift_of(r.tx_sr, lsb_first);
                  end
                  next_r.st = ST_XFER;
               end
            end
            ST_XFER: begin
               if (tk.tick) begin
                  next_r.sclk_o = ~r.sclk_o;
                  next_r.edges = r.edges + 5'h01;
                  lead = ~r.edges[0];
                  if (lead ^ cpha) begin
                     next_r.rx_sr = ins_of(r.rx_sr, lsb_first, din);
                  end else begin
                     next_r.out_bit = out_of(r.tx_sr, lsb_first);
                     next_r.tx_sr = shift_of(r.tx_sr, lsb_first);
                  end
                  if (r.edges == LAST_EDGE) begin
                     rx_done = 1'b1;
                     next_r.st = ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               if (tk.tick) begin
                  if (!manual_select_mode) begin
                     next_r.cs_reg = 1'b1;
                  end else if (r.cur_code == CS_CODE_HIGH) begin
                     next_r.cs_reg = 1'b1;
                  end
                  next_r.st = ST_IDLE;
               end
            end
         endcase
      end else begin
         next_r.st = ST_IDLE;
         next_r.sclk_o = cpol;
         sel_n = r.s2[PIN_CS];
         din = r.s2[PIN_MOSI];
         if (r.cs_p && !sel_n) begin
            // select edge frames a byte; buffer must already hold it
            next_r.bits = '0;
            next_r.drive = r.tx_full;
            next_r.tx_sr = r.tx_full ? r.tx_hold : FILL_BYTE;
            if (r.tx_full) begin
               next_r.tx_full = 1'b0;
            end
            if (!cpha) begin
               next_r.out_bit = out_of(next_r.tx_sr, lsb_first);
               next_r.tx_sr = shift_of(next_r.tx_sr, lsb_first);
            end
         end else if (!sel_n && (r.s2[PIN_SCLK] != r.sclk_p)) begin
            lead = (r.s2[PIN_SCLK] != cpol);
            if (lead ^ cpha) begin
               next_r.rx_sr = ins_of(r.rx_sr, lsb_first, din);
               next_r.bits = r.bits + 4'h1;
               if (r.bits == LAST_BIT) begin
                  // cs held low: next byte follows, reloaded plain
                  rx_done = 1'b1;
                  next_r.bits = '0;
                  next_r.drive = r.tx_full;
                  next_r.tx_sr = r.tx_full ? r.tx_hold : FILL_BYTE;
                  if (r.tx_full) begin
                     next_r.tx_full = 1'b0;
                  end
               end
            end else begin
               next_r.out_bit = out_of(r.tx_sr, lsb_first);
               next_r.tx_sr = shift_of(r.tx_sr, lsb_first);
            end
         end
      end

      // receive hold: a waiting command is answered once a byte sits here
      if (clear_rx) begin
         next_r.rx_full = 1'b0;
         next_r.rx_wait = 1'b0;
      end else if (r.rx_wait && r.rx_full) begin
         next_r.rx_valid = 1'b1;
         next_r.rx_data = r.rx_hold;
         next_r.rx_full = 1'b0;
         next_r.rx_wait = spi_receive_command;
      end
      // arrival wins over the take in the same cycle
      if (rx_done) begin
         next_r.rx_hold = next_r.rx_sr;
         next_r.rx_full = 1'b1;
      end

      // pin directions; oe_n low means driven
      next_r.sclk_out = next_r.sclk_o;
      next_r.cs_out = next_r.cs_reg;
      next_r.mosi_out = next_r.out_bit;
      next_r.miso_out = next_r.out_bit;
      if (!enable) begin
         next_r.miso_oe_n = 1'b1;
         next_r.mosi_oe_n = 1'b1;
         next_r.sclk_oe_n = 1'b1;
         next_r.cs_oe_n = 1'b1;
      end else if (master_mode) begin
         next_r.miso_oe_n = 1'b1;
         next_r.sclk_oe_n = 1'b0;
         next_r.cs_oe_n = 1'b0;
         next_r.mosi_oe_n = half_duplex
                          && !(next_r.drive && next_r.st != ST_IDLE);
      end else begin
         next_r.sclk_oe_n = 1'b1;
         next_r.cs_oe_n = 1'b1;
         next_r.miso_oe_n = half_duplex || r.s2[PIN_CS];
         next_r.mosi_oe_n = !(half_duplex && next_r.drive && !r.s2[PIN_CS]);
      end
      next_r.tx_ready = !next_r.tx_full;
      next_r.cs_level = master_mode ? next_r.cs_reg : r.s2[PIN_CS];
      next_r.busy = master_mode ? (next_r.st != ST_IDLE) : !r.s2[PIN_CS];
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r <= CORE_RST;
      end else begin
         r <= next_r;
      end
   end

   assign tx_ready = r.tx_ready;
   assign rx_valid = r.rx_valid;
   assign rx_data = r.rx_data;
   assign cs_level = r.cs_level;
   assign busy = r.busy;
   assign miso_out = r.miso_out;
   assign miso_oe_n = r.miso_oe_n;
   assign mosi_out = r.mosi_out;
   assign mosi_oe_n = r.mosi_oe_n;
   assign sclk_out = r.sclk_out;
   assign sclk_oe_n = r.sclk_oe_n;
   assign cs_out = r.cs_out;
   assign cs_oe_n = r.cs_oe_n;
endmodule
`default_nettype wire

// ### bench/spimsp_slv.sv
// behavioural spi slave standing on the far side of the port
// assumes the port is master; mode inputs shared with the bench
`timescale 1ns/1ps
`default_nettype none
module spimsp_slv (
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb,
   input wire logic [7:0] txb,
   output logic miso,
   output logic [7:0] rxb
);
   int n = 8;
   logic [7:0] sh;
   initial miso = 1'b0;
   function automatic int ix(int k);
      return lsb ? k : 7 - k;
   endfunction
   always @(negedge cs_n) begin
      n = 0;
      sh = txb;
      if (!cpha) miso = sh[ix(0)];
   end
   // released line must not keep the last bit
   always @(posedge cs_n) miso = ~miso;
   always @(sclk) if (!cs_n && n < 8) begin
      if (sclk == (cpol == cpha)) begin
         rxb[ix(n)] = mosi;
         n++;
      end else if (cpha || n > 0) miso = sh[ix(n)];
   end
endmodule
`default_nettype wire

// ### bench/spimsp_chk.sv
// pin and timing assertions for the spi port core
// assumes bind onto spimsp_core; everything sampled on mclk
`timescale 1ns/1ps
`default_nettype none
module spimsp_chk
   import spimsp_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic master_mode,
   input wire logic half_duplex,
   input wire logic [spimsp_pkg::SEL_W-1:0] clk_sel,
   input wire logic cpol,
   input wire logic manual_select_mode,
   input wire logic chip_select_set_command,
   input wire logic cs_set_value,
   input wire logic tx_valid,
   input wire logic spi_receive_command,
   input wire logic busy,
   input wire logic miso_oe_n,
   input wire logic mosi_oe_n,
   input wire logic sclk_out,
   input wire logic sclk_oe_n,
   input wire logic cs_out,
   input wire logic cs_oe_n
);
   import spimsp_pkg::*;
   localparam int HP[SEL_N] = '{3, 5, 9, 17, 34, 67, 134, 267};
   logic [1:0] up;
   logic ps, pc, vld;
   int cnt;
   wire logic m = enable && master_mode && up == 2'h3;
   wire logic [3:0] cf = {enable, master_mode, half_duplex, cpol};
   wire logic tg = sclk_out != ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // first interval of a byte carries setup latency, so it is not timed
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         up <= 2'h0;
         ps <= 1'b0;
         pc <= 1'b1;
         vld <= 1'b0;
         cnt <= 0;
      end else begin
         up <= (up == 2'h3) ? up : up + 2'h1;
         ps <= sclk_out;
         pc <= cs_out;
         cnt <= tg ? 1 : cnt + 1;
         vld <= busy && cs_out == pc && (vld || tg);
      end
   end
   property p_mst_dir;
      m && !half_duplex && $stable(cf) |-> !sclk_oe_n && !cs_oe_n && !mosi_oe_n && miso_oe_n;
   endproperty
   a_mst_dir: assert property (p_mst_dir) else $error("master pins misdriven");
   property p_slv_dir;
      enable && !master_mode && !half_duplex && up == 2'h3 && $stable(cf)
         |-> sclk_oe_n && cs_oe_n && mosi_oe_n;
   endproperty
   a_slv_dir: assert property (p_slv_dir) else $error("slave pins misdriven");
   property p_half;
      enable && half_duplex && up == 2'h3 && $stable(cf) |-> miso_oe_n;
   endproperty
   a_half: assert property (p_half) else $error("miso driven in half duplex");
   property p_idle; m && !busy && $stable(cf) |-> sclk_out == cpol; endproperty
   a_idle: assert property (p_idle) else $error("idle clock level wrong");
   property p_rate; m && vld && tg && $stable(clk_sel) |-> cnt == HP[clk_sel]; endproperty
   a_rate: assert property (p_rate) else $error("half period wrong");
   property p_auto; m && !manual_select_mode && busy && tg |-> !cs_out; endproperty
   a_auto: assert property (p_auto) else $error("clock runs unselected");
   property p_auto_end; m && !manual_select_mode && $fell(busy) |-> cs_out; endproperty
   a_auto_end: assert property (p_auto_end) else $error("cs low after byte");
   property p_man_set;
      m && manual_select_mode && chip_select_set_command && !busy
         |-> ##[1:3] cs_out == cs_set_value;
   endproperty
   a_man_set: assert property (p_man_set) else $error("cs set ignored");
   property p_man_hold;
      m && manual_select_mode && $stable(manual_select_mode) && !busy && !$past(busy)
         && !$past(tx_valid) && !$past(chip_select_set_command) && !$past(spi_receive_command)
         |-> $stable(cs_out);
   endproperty
   a_man_hold: assert property (p_man_hold) else $error("cs moved unasked");
   c_mst: cover property (m && $fell(busy));
   c_slv: cover property (!master_mode && $fell(busy));
   c_man: cover property (m && manual_select_mode && chip_select_set_command);
endmodule
bind spimsp_core spimsp_chk i_spimsp_chk (
   .mclk(mclk), .nrst(nrst), .enable(enable), .master_mode(master_mode),
   .half_duplex(half_duplex), .clk_sel(clk_sel), .cpol(cpol),
   .manual_select_mode(manual_select_mode), .chip_select_set_command(chip_select_set_command),
   .cs_set_value(cs_set_value), .tx_valid(tx_valid), .spi_receive_command(spi_receive_command),
   .busy(busy), .miso_oe_n(miso_oe_n), .mosi_oe_n(mosi_oe_n), .sclk_out(sclk_out),
   .sclk_oe_n(sclk_oe_n), .cs_out(cs_out), .cs_oe_n(cs_oe_n)
);
`default_nettype wire

// ### bench/spimsp_core_tb.sv
// self-checking bench: master modes, manual cs, half duplex fill, slave bytes
// assumes spimsp_slv and the checker bind compiled alongside
`timescale 1ns/1ps
`default_nettype none
module spimsp_core_tb;
   import spimsp_pkg::*;
   logic mclk = 1'b0, nrst = 1'b0, enable = 1'b1, master_mode = 1'b1, half_duplex = 1'b0;
   logic cpol = 1'b0, cpha = 1'b0, lsb_first = 1'b0, manual_select_mode = 1'b0;
   logic chip_select_set_command = 1'b0, cs_set_value = 1'b1, tx_valid = 1'b0;
   logic spi_receive_command = 1'b0, clear_tx = 1'b0, clear_rx = 1'b0;
   logic [2:0] clk_sel = 3'h0;
   logic [1:0] tx_cs_code = 2'h0, rx_cs_code = 2'h0;
   logic [7:0] tx_data = 8'h00, s_tx = 8'h00, rx_data, s_rx;
   logic tx_ready, rx_valid, cs_level, busy, s_miso, m_sclk = 1'b0, m_cs = 1'b1, m_mosi = 1'b0;
   logic miso_in, miso_out, miso_oe_n, mosi_in, mosi_out, mosi_oe_n;
   logic sclk_in, sclk_out, sclk_oe_n, cs_in, cs_out, cs_oe_n;
   logic [7:0] q[$];
   int n_mismatch = 0, check_count = 0;
   always #5 mclk = ~mclk;
   assign sclk_in = sclk_oe_n ? m_sclk : sclk_out;
   assign cs_in = cs_oe_n ? m_cs : cs_out;
   assign miso_in = miso_oe_n ? s_miso : miso_out;
   assign mosi_in = !mosi_oe_n ? mosi_out : half_duplex ? s_miso : m_mosi;
   spimsp_core i_spimsp_core (
      .mclk(mclk), .nrst(nrst), .enable(enable), .master_mode(master_mode),
      .half_duplex(half_duplex), .clk_sel(clk_sel), .cpol(cpol), .cpha(cpha),
      .lsb_first(lsb_first), .manual_select_mode(manual_select_mode),
      .chip_select_set_command(chip_select_set_command), .cs_set_value(cs_set_value),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_cs_code(tx_cs_code), .tx_ready(tx_ready),
      .clear_tx(clear_tx), .spi_receive_command(spi_receive_command),
      .rx_cs_code(rx_cs_code), .clear_rx(clear_rx), .rx_valid(rx_valid), .rx_data(rx_data),
      .cs_level(cs_level), .busy(busy),
      .miso_in(miso_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
      .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
      .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
      .cs_in(cs_in), .cs_out(cs_out), .cs_oe_n(cs_oe_n)
   );
   spimsp_slv i_spimsp_slv (.sclk(sclk_in), .cs_n(cs_in), .mosi(mosi_in), .cpol(cpol),
      .cpha(cpha), .lsb(lsb_first), .txb(s_tx), .miso(s_miso), .rxb(s_rx));
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
   endtask
   task automatic wt(input logic v);
      // v high waits for busy, v low waits for the receive queue as well
      for (int k = 0; busy !== v || (!v && q.size() > 0); k++) begin
         if (k > 9000) begin
            n_mismatch++;
            $display("BAD %0t wait ran out", $time);
            test_done();
         end
         @(posedge mclk);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic [1:0] c);
      @(posedge mclk);
      tx_valid <= 1'b1;
      tx_data <= b;
      tx_cs_code <= c;
      @(posedge mclk);
      tx_valid <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] b, input logic [1:0] c);
      send(b, c);
      wt(1'b1);
      wt(1'b0);
      tick(2);
   endtask
   task automatic rxcmd(input logic [7:0] e);
      q.push_back(e);
      @(posedge mclk);
      spi_receive_command <= 1'b1;
      @(posedge mclk);
      spi_receive_command <= 1'b0;
   endtask
   task automatic csset(input logic v);
      @(posedge mclk);
      chip_select_set_command <= 1'b1;
      cs_set_value <= v;
      @(posedge mclk);
      chip_select_set_command <= 1'b0;
      tick(4);
      chk(8'(cs_level), 8'(v));
   endtask
   task automatic mbyte(input logic [7:0] b, output logic [7:0] got);
      m_cs <= 1'b0;
      tick(8);
      for (int j = 7; j >= 0; j--) begin
         m_mosi <= b[j];
         tick(4);
         m_sclk <= 1'b1;
         tick(4);
         got[j] = miso_in;
         m_sclk <= 1'b0;
      end
      tick(4);
      m_cs <= 1'b1;
      m_mosi <= ~m_mosi;
   endtask
   always @(posedge mclk) if (rx_valid === 1'b1) begin
      // a byte nobody asked for: always a mismatch, even with unknown data
      if (q.size() == 0) chk(8'(q.size()), 8'h01);
      else chk(rx_data, q.pop_front());
   end
   initial begin
      logic [7:0] b, e, got;
      void'($urandom(62));
      tick(10);
      nrst <= 1'b1;
      tick(4);
      for (int i = 0; i < 8; i++) begin
         cpol <= i[0];
         cpha <= i[1];
         lsb_first <= i[2];
         clk_sel <= (i == 7) ? 3'h7 : 3'($urandom % 4);
         b = 8'($urandom);
         s_tx = 8'($urandom);
         tick(3);
         xfer(b, CS_CODE_NONE);
         chk(s_rx, b);
         rxcmd(s_tx);
         wt(1'b0);
      end
      $display("test master modes done");
      manual_select_mode <= 1'b1;
      csset(1'b0);
      b = 8'($urandom);
      xfer(b, CS_CODE_HIGH);
      chk(8'(cs_level), 8'h01);
      chk(s_rx, b);
      xfer(~b, CS_CODE_LOW);
      chk(8'(cs_level), 8'h00);
      csset(1'b1);
      $display("test manual select done");
      half_duplex <= 1'b1;
      rx_cs_code <= CS_CODE_LOW;
      clear_rx <= 1'b1;
      @(posedge mclk);
      clear_rx <= 1'b0;
      s_tx = 8'($urandom);
      tick(3);
      rxcmd(s_tx);
      wt(1'b0);
      chk(8'(cs_level), 8'h00);
      $display("test half duplex done");
      manual_select_mode <= 1'b0;
      half_duplex <= 1'b0;
      master_mode <= 1'b0;
      cpol <= 1'b0;
      cpha <= 1'b0;
      lsb_first <= 1'b0;
      tick(4);
      for (int k = 0; k < 2; k++) begin
         b = 8'($urandom);
         e = 8'($urandom);
         send(e, CS_CODE_NONE);
         if (k != 0) begin
            // cleared buffer leaves the fill byte to go out
            clear_tx <= 1'b1;
            @(posedge mclk);
            clear_tx <= 1'b0;
         end
         rxcmd(b);
         mbyte(b, got);
         chk(got, (k != 0) ? FILL_BYTE : e);
         wt(1'b0);
         chk(8'(tx_ready), 8'h01);
      end
      $display("test slave done");
      enable <= 1'b0;
      tick(3);
      chk(8'({miso_oe_n, mosi_oe_n, sclk_oe_n, cs_oe_n}), 8'h0F);
      $display("test disable done");
      test_done();
   end
endmodule
`default_nettype wire
